// ---- bench/rx_model.sv ----
/*
  Receiver model: counts the slots that carry generated pattern words.
  Assumes out_test marks those slots on pclk.
*/
module rx_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // slot flag
  input wire logic test,
  // pattern slots seen
  output logic [15:0] count
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (test) begin
      count <= count + 16'h0001;
    end
  end
endmodule : rx_model

// ---- bench/tb.sv ----
/*
  Self-checking bench for tpg_top: registers, mode table, increment,
  prbs and framed lines.
  Assumes one wait state per apb transfer, as the design answers.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpg_pkg::*;
  localparam int N = NUM_CH_DEF;
  localparam int W = WORD_W_DEF;
  typedef struct packed {
    logic [4:0] ctrl;
    mode_e md;
    logic tst;
    logic [1:0] sel;
  } row_s;
  row_s rows [7] = '{
    '{5'h00, MODE_NORMAL, 1'b0, 2'h0},
    '{5'h02, MODE_NORMAL, 1'b0, 2'h0},
    '{5'h01, MODE_FIXED, 1'b1, 2'h1},
    '{5'h11, MODE_FIXED, 1'b1, 2'h2},
    '{5'h08, MODE_NORMAL, 1'b0, 2'h0},
    '{5'h09, MODE_FIXED, 1'b0, 2'h0},
    '{5'h07, MODE_PRBS, 1'b1, 2'h3}};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, line_start = 1'b0, in_window = 1'b0;
  logic crc_slot = 1'b0, pready, pslverr, out_crc_slot, out_test, er;
  logic [11:0] paddr = 12'h000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [N*W-1:0] src_data = {N{10'h2a5}}, out_data;
  logic [15:0] rx_cnt, n0;
  logic [W-1:0] e [N];
  int miscompares = 0, num_checks = 0, cyc = 0;
  always #2 pclk = ~pclk;
  tpg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_start(line_start), .in_window(in_window), .crc_slot(crc_slot),
    .src_data(src_data), .out_data(out_data),
    .out_crc_slot(out_crc_slot), .out_test(out_test));
  rx_model rx_u (.pclk(pclk), .presetn(presetn), .test(out_test),
    .count(rx_cnt));
  function automatic logic [W-1:0] sd(input int c);
    return W'(10'h3f8 + c);
  endfunction : sd
  function automatic logic [W-1:0] xw(input logic [1:0] s, input int c);
    return (s == 2'h0) ? 10'h2a5 : (s == 2'h1) ? sd(c) : sd(c) >> DROP_LSBS;
  endfunction : xw
  function automatic logic [W-1:0] nx(input logic [W-1:0] v);
    repeat (W) v = {v[W-2:0], ^(v & W'(PRBS_TAPS_DEF))};
    return v;
  endfunction : nx
  task automatic chk(input string nm, input logic [31:0] ex, got);
    num_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // starts with an edge so back-to-back calls never drive psel twice
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic gen_run(input logic [4:0] ct);
    apb(1'b1, ADDR_CTRL, 32'h0);
    tick(2);
    apb(1'b1, ADDR_CTRL, 32'(ct));
    for (int c = 0; c < N; c++) e[c] = sd(c);
    do @(posedge pclk); while (out_test !== 1'b1);
    repeat (12) begin
      chk("gen slot", 32'h1, 32'(out_test));
      for (int c = 0; c < N; c++) begin
        chk("gen word", e[c], out_data[c*W +: W]);
        e[c] = ct[2] ? nx(e[c]) : (e[c] == '1) ? sd(c) : e[c] + 1'b1;
      end
      @(posedge pclk);
    end
  endtask : gen_run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    tick(5);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, ADDR_SEED_BASE, 32'h0);
    chk("seed reset", 32'h0, rd);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    for (int c = 0; c < N; c++) begin
      apb(1'b1, ADDR_SEED_BASE + 12'(4 * c), sd(c));
    end
    foreach (rows[i]) begin
      apb(1'b1, ADDR_CTRL, 32'(rows[i].ctrl));
      tick(3);
      chk("out_test", 32'(rows[i].tst), 32'(out_test));
      for (int c = 0; c < N; c++) begin
        if (rows[i].sel != 2'h3) begin
          chk("out_data", xw(rows[i].sel, c), out_data[c*W +: W]);
        end
      end
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("mode", 32'(rows[i].md), 32'(rd[3:0]));
    end
    gen_run(5'h03);
    gen_run(5'h04);
    apb(1'b1, ADDR_CTRL, 32'h0b);
    // let the last prbs slots drain out of the receiver count first
    tick(2);
    n0 = rx_cnt;
    in_window <= 1'b1;
    tick(3);
    in_window <= 1'b0;
    crc_slot <= 1'b1;
    tick(1);
    crc_slot <= 1'b0;
    line_start <= 1'b1;
    tick(1);
    chk("crc slot", 32'h1, 32'(out_crc_slot));
    chk("crc data", 32'h2a5, 32'(out_data[W-1:0]));
    line_start <= 1'b0;
    in_window <= 1'b1;
    tick(2);
    chk("window slots", 32'h3, 32'(rx_cnt - n0));
    for (int c = 0; c < N; c++) begin
      chk("line reload", sd(c), out_data[c*W +: W]);
    end
    in_window <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h0c);
    crc_slot <= 1'b1;
    tick(1);
    crc_slot <= 1'b0;
    tick(1);
    chk("prbs crc word", 32'h1, 32'(out_test));
    chk("prbs crc flag", 32'h0, 32'(out_crc_slot));
    apb(1'b0, ADDR_LINES, 32'h0);
    chk("line count", 32'h1, rd);
    // lane 1 only: clears seed bits 9:8, keeps the low byte
    pstrb <= 4'h2;
    apb(1'b1, ADDR_SEED_BASE, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_SEED_BASE, 32'h0);
    chk("strobe merge", 32'h0f8, rd);
    // reset in mid-run clears the stream and the registers
    presetn <= 1'b0;
    tick(2);
    chk("reset test flag", 32'h0, 32'(out_test));
    chk("reset data", 32'h0, 32'(out_data != '0));
    chk("reset ready", 32'h0, 32'(pready));
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl after reset", 32'h0, rd);
    apb(1'b0, ADDR_LINES, 32'h0);
    chk("lines after reset", 32'h0, rd);
    stop_test();
  end
endmodule : tb

// ---- bench/tpg_checker.sv ----
/*
  Port assertions for tpg_top.
  Assumes control writes use all byte lanes.
*/
module tpg_checker import tpg_pkg::*; #(
  parameter int NUM_CH = 8,
  parameter int WORD_W = 10
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // stream
  input wire logic in_window,
  input wire logic crc_slot,
  input wire logic [NUM_CH*WORD_W-1:0] src_data,
  input wire logic [NUM_CH*WORD_W-1:0] out_data,
  input wire logic out_crc_slot,
  input wire logic out_test
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] c;
  logic wr, gen, inc, fx;
  logic [WORD_W-1:0] w0;
  assign wr = psel && penable && pready && pwrite;
  assign gen = c[0] | c[2];
  assign inc = (c == 5'h03);
  assign fx = (c == 5'h01) && !wr;
  assign w0 = out_data[WORD_W-1:0];
  // shadow of the control word, updated at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c <= 5'h00;
    end else if (wr && paddr == ADDR_CTRL) begin
      c <= pwdata[4:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && !penable ##1 psel && penable
    |-> !pready ##1 pready) else $error("apb wait state wrong");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unframed_gen: assert property (
    gen && !c[3] |=> out_test && !out_crc_slot)
    else $error("unframed slot not generated");
  a_framed_idle: assert property (
    gen && c[3] && !in_window && !crc_slot
    |=> !out_test && out_data == $past(src_data))
    else $error("framed idle slot altered");
  a_framed_crc: assert property (
    c[0] && !c[2] && c[3] && crc_slot && !in_window
    |=> out_crc_slot && out_data == $past(src_data))
    else $error("checksum slot not kept");
  a_prbs_crc: assert property (
    c[2] && c[3] && crc_slot |=> out_test && !out_crc_slot)
    else $error("prbs checksum slot wrong");
  a_normal_pass: assert property (
    !gen |=> !out_test && out_data == $past(src_data))
    else $error("normal stream altered");
  a_eight_drop: assert property (
    c[4] && gen |=> !out_test || w0[WORD_W-1 -: DROP_LSBS] == '0)
    else $error("high bits set in 8-bit word");
  a_fixed_hold: assert property (
    !wr ##1 fx ##1 fx |=> $stable(out_data))
    else $error("fixed word changed");
  a_inc_step: assert property (
    inc && !wr ##1 inc && !wr && out_test && w0 != '1
    |=> w0 == $past(w0) + 1'b1) else $error("increment step wrong");
  c_inc_wrap: cover property (inc && out_test && w0 == '1);
  c_frame_crc: cover property (c[3] && crc_slot && gen);
  c_err: cover property (pslverr);
endmodule : tpg_checker

bind tpg_top tpg_checker #(.NUM_CH(NUM_CH), .WORD_W(WORD_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .in_window(in_window), .crc_slot(crc_slot),
  .src_data(src_data), .out_data(out_data),
  .out_crc_slot(out_crc_slot), .out_test(out_test));

// ---- verilog/tpg_channel.sv ----
/*
  One data channel's pattern source: fixed word, incrementing word or
  prbs word, all built from the channel's own seed.
  Assumes the parent decides when a word is consumed (advance) and when
  a line starts (reload); same clock as the parent.
*/
module tpg_channel #(
  parameter int WORD_W = tpg_pkg::WORD_W_DEF,
  parameter logic [WORD_W-1:0] PRBS_TAPS = WORD_W'(tpg_pkg::PRBS_TAPS_DEF)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the parent
  input wire logic [WORD_W-1:0] seed,
  input wire tpg_pkg::mode_e mode,
  input wire logic advance,
  input wire logic reload,
  // current pattern word
  output logic [WORD_W-1:0] word
);
  import tpg_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] word;
  } chan_s;

  chan_s r;
  chan_s next_r;

  localparam logic [WORD_W-1:0] WORD_MAX = {WORD_W{1'b1}};

  // one whole word of lfsr shifts per output word; an all-zero state
  // stays zero, so a zero seed yields no random data
  function automatic logic [WORD_W-1:0] prbs_step(
    input logic [WORD_W-1:0] s);
    logic [WORD_W-1:0] v;
    logic fb;
    v = s;
    fb = 1'b0;
    for (int i = 0; i < WORD_W; i++) begin
      fb = ^(v & PRBS_TAPS);
      v = {v[WORD_W-2:0], fb};
    end
    return v;
  endfunction : prbs_step

  always_comb begin
    next_r = r;
    unique case (mode)
      MODE_NORMAL, MODE_FIXED: begin
        // holding the seed here means a mode entered from normal or fixed starts from it
        next_r.word = seed;
      end
      MODE_INC: begin
        if (reload) begin
          next_r.word = seed;
        end else if (advance) begin
          if (r.word == WORD_MAX) begin
            next_r.word = seed;
          end else begin
            next_r.word = r.word + 1'b1;
          end
        end
      end
      MODE_PRBS: begin
        if (advance) begin
          next_r.word = prbs_step(r.word);
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign word = r.word;

endmodule : tpg_channel

// ---- verilog/tpg_pkg.sv ----
/*
  Shared constants, register map and mode type for the data channel test
  pattern generator.
  Assumes a single clock domain and a 32-bit APB register port.
*/
package tpg_pkg;

  // structure defaults
  localparam int NUM_CH_DEF = 8;
  localparam int WORD_W_DEF = 10;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_LINES = 12'h008;
  localparam logic [11:0] ADDR_SEED_BASE = 12'h040;
  localparam logic [11:0] ADDR_WORD_BASE = 12'h080;

  // control register fields
  localparam int CTRL_INJECT_BIT = 0;
  localparam int CTRL_INC_BIT = 1;
  localparam int CTRL_PRBS_BIT = 2;
  localparam int CTRL_FRAME_BIT = 3;
  localparam int CTRL_EIGHT_BIT = 4;
  localparam int CTRL_W = 5;

  // status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_TEST_BIT = 4;
  localparam int STAT_WINDOW_BIT = 5;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam int SEED_RESET = 0;
  localparam logic [15:0] LINES_RESET = 16'h0000;

  // bits dropped from each generated word in 8-bit output
  localparam int DROP_LSBS = 2;

  // prbs feedback taps for the default word width (x^10 + x^7 + 1)
  localparam int PRBS_TAPS_DEF = 'h240;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_FIXED = 4'b0010,
    MODE_INC = 4'b0100,
    MODE_PRBS = 4'b1000
  } mode_e;

  function automatic mode_e mode_decode(input logic inject,
                                        input logic inc,
                                        input logic prbs);
    if (prbs) begin
      return MODE_PRBS;
    end else if (inject && inc) begin
      return MODE_INC;
    end else if (inject) begin
      return MODE_FIXED;
    end
    return MODE_NORMAL;
  endfunction : mode_decode

endpackage : tpg_pkg

// ---- verilog/tpg_top.sv ----
/*
  Test pattern injection for the serial data channels, with its APB
  register file. Generated words replace the converter stream either
  inside the line windows or continuously.
  Assumes the sequencer and the converter path run on pclk; their
  markers and the normal stream (training words included) arrive
  already aligned, and a downstream unit fills the checksum slot when
  out_crc_slot is high.
*/
// The implementer's own choices: the address map and the APB register port.
// Summary of operation
// - in fixed mode each channel repeats its own programmed word.
// - in increment mode the channel word rises by one per output word.
// - past its maximum the incrementing word restarts from its seed.
// - framed increment mode also restarts from the seed at line start.
// - prbs mode sends a sequence seeded by each channel's own word.
// - unframed prbs is an unbroken stream with no training or gaps.
// - prbs mode fills the checksum slot with one more prbs word.
// - every channel has its own independent generator.
// - prbs wins, then inject with increment, then inject, then normal.
// - framed, test data sits only inside windows, plus the checksum slot in prbs mode; checksum kept otherwise.
// - unframed, generated data replaces the whole output stream.
// - 8-bit output drops the two low bits of each generated word.
module tpg_top #(
  parameter int NUM_CH = tpg_pkg::NUM_CH_DEF,
  parameter int WORD_W = tpg_pkg::WORD_W_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sequencer markers and the normal channel stream
  input wire logic line_start,
  input wire logic in_window,
  input wire logic crc_slot,
  input wire logic [NUM_CH*WORD_W-1:0] src_data,
  // channel stream towards the serialisers
  output logic [NUM_CH*WORD_W-1:0] out_data,
  output logic out_crc_slot,
  output logic out_test
);
  import tpg_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [NUM_CH-1:0][WORD_W-1:0] seed;
    logic [15:0] lines;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NUM_CH-1:0][WORD_W-1:0] out_data;
    logic out_crc_slot;
    logic out_test;
  } state_s;

  state_s r;
  state_s next_r;

  mode_e mode;
  logic framed;
  logic eight_bit;
  logic gen_slot;
  logic advance;
  logic reload;
  logic [NUM_CH-1:0][WORD_W-1:0] gen_word;
  logic [NUM_CH-1:0][WORD_W-1:0] src_word;

  // byte-lane merge of a write into an existing register value
  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    return v;
  endfunction : apply_strb

  // shapes a generated word for the selected output width
  function automatic logic [WORD_W-1:0] fmt_word(
    input logic [WORD_W-1:0] w,
    input logic eight);
    if (eight) begin
      return w >> DROP_LSBS;
    end
    return w;
  endfunction : fmt_word

  // the increment select alone leaves normal data; see mode_decode
  assign mode = mode_decode(r.ctrl[CTRL_INJECT_BIT],
                            r.ctrl[CTRL_INC_BIT],
                            r.ctrl[CTRL_PRBS_BIT]);
  assign framed = r.ctrl[CTRL_FRAME_BIT];
  assign eight_bit = r.ctrl[CTRL_EIGHT_BIT];
  assign src_word = src_data;

  // a generated word goes out in this slot; framed prbs also takes the
  // checksum slot, unframed test data takes every slot
  always_comb begin
    if (mode == MODE_NORMAL) begin
      gen_slot = 1'b0;
    end else if (!framed) begin
      gen_slot = 1'b1;
    end else if (in_window) begin
      gen_slot = 1'b1;
    end else if (crc_slot && mode == MODE_PRBS) begin
      gen_slot = 1'b1;
    end else begin
      gen_slot = 1'b0;
    end
  end

  assign advance = gen_slot;
  assign reload = framed && line_start;

  // one generator per channel, each with its own seed and state
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    tpg_channel #(
      .WORD_W(WORD_W)
    ) u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .seed(r.seed[c]),
      .mode(mode),
      .advance(advance),
      .reload(reload),
      .word(gen_word[c])
    );
  end

  always_comb begin
    logic [31:0] merged;
    logic hit;
    merged = '0;
    hit = 1'b0;
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;

    // apb: one wait state, then pready with registered read data
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      if (paddr == ADDR_CTRL) begin
        hit = 1'b1;
        next_r.prdata[CTRL_W-1:0] = r.ctrl;
      end else if (paddr == ADDR_STATUS) begin
        hit = 1'b1;
        next_r.prdata[STAT_MODE_LSB +: 4] = mode;
        next_r.prdata[STAT_TEST_BIT] = r.out_test;
        next_r.prdata[STAT_WINDOW_BIT] = in_window;
      end else if (paddr == ADDR_LINES) begin
        hit = 1'b1;
        next_r.prdata[15:0] = r.lines;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (paddr == ADDR_SEED_BASE + 12'(4 * c)) begin
          hit = 1'b1;
          next_r.prdata[WORD_W-1:0] = r.seed[c];
        end
        if (paddr == ADDR_WORD_BASE + 12'(4 * c)) begin
          hit = 1'b1;
          next_r.prdata[WORD_W-1:0] = gen_word[c];
        end
      end
      // unmapped addresses answer with an error and zero data
      next_r.pslverr = !hit;
    end

    // writes land at the completing edge only
    if (psel && penable && r.pready && pwrite && !r.pslverr) begin
      if (paddr == ADDR_CTRL) begin
        merged = apply_strb(32'(r.ctrl), pwdata, pstrb);
        next_r.ctrl = merged[CTRL_W-1:0];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (paddr == ADDR_SEED_BASE + 12'(4 * c)) begin
          merged = apply_strb(32'(r.seed[c]), pwdata, pstrb);
          next_r.seed[c] = merged[WORD_W-1:0];
        end
      end
    end

    // line counter for software visibility; a counter write is ignored
    if (line_start) begin
      next_r.lines = r.lines + 16'h0001;
    end

    // output stream selection
    next_r.out_test = gen_slot;
    if (gen_slot) begin
      for (int c = 0; c < NUM_CH; c++) begin
        next_r.out_data[c] = fmt_word(gen_word[c], eight_bit);
      end
      next_r.out_crc_slot = 1'b0;
    end else begin
      // outside windows the normal stream carries the training words
      next_r.out_data = src_word;
      // unframed test data never hands a slot to the checksum unit
      next_r.out_crc_slot = crc_slot && (mode == MODE_NORMAL || framed);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.ctrl <= CTRL_RESET;
      r.seed <= {NUM_CH{WORD_W'(SEED_RESET)}};
      r.lines <= LINES_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign out_data = r.out_data;
  assign out_crc_slot = r.out_crc_slot;
  assign out_test = r.out_test;

endmodule : tpg_top
